// ### hw/acr_pkg.sv
// constants for the comparator control register bank
package acr_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int unsigned ACR_ADDR_W = 8;
  localparam int unsigned ACR_DATA_W = 32;
  localparam int unsigned ACR_IDX_LSB = 2;
  localparam int unsigned ACR_IDX_W = ACR_ADDR_W - ACR_IDX_LSB;

  // ----------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [ACR_IDX_W-1:0] ACR_IDX_CTRL = 6'h00;
  localparam logic [ACR_IDX_W-1:0] ACR_IDX_MUX = 6'h02;
  localparam logic [ACR_IDX_W-1:0] ACR_IDX_DREF = 6'h04;
  localparam logic [ACR_IDX_W-1:0] ACR_IDX_IEN = 6'h06;
  localparam logic [ACR_IDX_W-1:0] ACR_IDX_STAT = 6'h07;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ACR_CTRL_RST = 8'h00;
  localparam logic [7:0] ACR_MUX_RST = 8'h00;
  localparam logic [7:0] ACR_DREF_RST = 8'hff;
  localparam logic [7:0] ACR_IEN_RST = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned ACR_CTRL_RUNSTBY = 7;
  localparam int unsigned ACR_CTRL_PINEN = 6;
  localparam int unsigned ACR_CTRL_EDGE_HI = 5;
  localparam int unsigned ACR_CTRL_EDGE_LO = 4;
  localparam int unsigned ACR_CTRL_LOWCUR = 3;
  localparam int unsigned ACR_CTRL_HYS_HI = 2;
  localparam int unsigned ACR_CTRL_HYS_LO = 1;
  localparam int unsigned ACR_CTRL_EN = 0;
  localparam int unsigned ACR_MUX_INV = 7;
  localparam int unsigned ACR_MUX_POS_HI = 4;
  localparam int unsigned ACR_MUX_POS_LO = 3;
  localparam int unsigned ACR_MUX_NEG_HI = 1;
  localparam int unsigned ACR_MUX_NEG_LO = 0;
  localparam int unsigned ACR_IEN_BIT = 0;
  localparam int unsigned ACR_STAT_STATE = 4;
  localparam int unsigned ACR_STAT_FLAG = 0;

  // writable bits of the input select register
  localparam logic [7:0] ACR_MUX_MASK = 8'h9b;

  // ----------------------------------------
  // interrupt edge codes
  // ----------------------------------------
  localparam logic [1:0] ACR_EDGE_ANY = 2'h0;
  localparam logic [1:0] ACR_EDGE_RSVD = 2'h1;
  localparam logic [1:0] ACR_EDGE_FALL = 2'h2;
  localparam logic [1:0] ACR_EDGE_RISE = 2'h3;

  // ----------------------------------------
  // bus responses
  // ----------------------------------------
  localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

endpackage

// ### hw/acr_regs.sv
// comparator control, status and interrupt registers behind an axi4-lite slave
//
// How it works
// - keep-running bit keeps comparator enabled in standby; clear halts it there.
// - while in standby no status bit is updated; the flag only clears on a write of one.
// - pin-enable bit routes comparator output to the pin driver.
// - edge field picks both, falling or rising edges; code one is reserved.
// - reduced-current bit drives the analog low-current control.
// - two-bit hysteresis field goes straight to the analog input stage.
// - enable bit turns comparator on; all control bits reset zero, read/write.
// - invert bit flips the output seen by pin, events and status.
// - positive select field chooses positive pin zero to three.
// - negative select picks negative pins zero to two, or divided reference.
// - eight-bit reference code, reset all ones, drives the divider.
// - interrupt enable bit, read/write, resets zero.
// - state bit shows synchronised output, readable three cycles after change.
// - interrupt flag cleared by writing one; zero leaves it.
// - interrupt request high while enable and flag are both set.
// - raw comparator output is an asynchronous level.
`timescale 1ns/1ns
module acr_regs
  import acr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic standby_sleep,
  input wire logic [ACR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ACR_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ACR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ACR_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_raw,
  output logic comp_enable,
  output logic reduced_current_select,
  output logic [1:0] hysteresis_level,
  output logic [1:0] positive_input_select,
  output logic [1:0] negative_input_select,
  output logic [7:0] divided_reference,
  output logic comp_pin_out,
  output logic comp_pin_oe,
  output logic comp_event,
  output logic comparator_irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mux;
    logic [7:0] dref;
    logic ien;
    logic flag;
    logic state;
    logic active;
    logic aw_have;
    logic [ACR_IDX_W-1:0] aw_idx;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } acr_state_t;

  acr_state_t st_reg;
  acr_state_t st_next;

  logic raw_sync;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  // raw output is asynchronous, two flops before any logic
  acr_sync u_sync (
    .clock(clock),
    .rst(rst),
    .din(comp_raw),
    .dout(raw_sync)
  );

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_ok;
  logic w_ok;
  logic do_write;
  logic [ACR_IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic [ACR_IDX_W-1:0] rd_idx;
  logic out_level;
  logic rise;
  logic fall;
  logic edge_hit;
  logic flag_clr;
  logic frozen;

  assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;

  always_comb begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    ar_take = s_axi_arvalid && s_axi_arready;
    aw_ok = st_reg.aw_have || aw_take;
    w_ok = st_reg.w_have || w_take;
    do_write = aw_ok && w_ok && !st_reg.bvalid;
    wr_idx = st_reg.aw_have ? st_reg.aw_idx : s_axi_awaddr[ACR_ADDR_W-1:ACR_IDX_LSB];
    wr_data = st_reg.w_have ? st_reg.w_data : s_axi_wdata[7:0];
    wr_lane0 = st_reg.w_have ? st_reg.w_lane0 : s_axi_wstrb[0];
    rd_idx = s_axi_araddr[ACR_ADDR_W-1:ACR_IDX_LSB];
  end

  // ----------------------------------------
  // output path and edge detect
  // ----------------------------------------
  always_comb begin
    // the inversion is applied before status, events and pin
    out_level = raw_sync ^ st_reg.mux[ACR_MUX_INV];
    rise = out_level && !st_reg.state;
    fall = !out_level && st_reg.state;
    // status and edge detection are held while standby_sleep is high
    frozen = standby_sleep;
    unique case (st_reg.ctrl[ACR_CTRL_EDGE_HI:ACR_CTRL_EDGE_LO])
      ACR_EDGE_ANY: edge_hit = rise || fall;
      ACR_EDGE_FALL: edge_hit = fall;
      ACR_EDGE_RISE: edge_hit = rise;
      ACR_EDGE_RSVD: edge_hit = 1'b0;
    endcase
    flag_clr = do_write && wr_lane0 && (wr_idx == ACR_IDX_STAT)
      && wr_data[ACR_STAT_FLAG];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;

    // write address and data taken in either order
    if (aw_take && !do_write) begin
      st_next.aw_have = 1'b1;
      st_next.aw_idx = s_axi_awaddr[ACR_ADDR_W-1:ACR_IDX_LSB];
    end
    if (w_take && !do_write) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end

    if (do_write) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = ACR_RESP_OKAY;
      // only byte lane zero carries register bits
      unique case (wr_idx)
        ACR_IDX_CTRL: begin
          if (wr_lane0) begin
            st_next.ctrl = wr_data;
          end
        end
        ACR_IDX_MUX: begin
          if (wr_lane0) begin
            st_next.mux = wr_data & ACR_MUX_MASK;
          end
        end
        ACR_IDX_DREF: begin
          if (wr_lane0) begin
            st_next.dref = wr_data;
          end
        end
        ACR_IDX_IEN: begin
          if (wr_lane0) begin
            st_next.ien = wr_data[ACR_IEN_BIT];
          end
        end
        ACR_IDX_STAT: begin
          st_next.bresp = ACR_RESP_OKAY;
        end
        default: begin
          st_next.bresp = ACR_RESP_SLVERR;
        end
      endcase
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // read answer registered one cycle after the address
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = ACR_RESP_OKAY;
      st_next.rdata = 8'h00;
      unique case (rd_idx)
        ACR_IDX_CTRL: st_next.rdata = st_reg.ctrl;
        ACR_IDX_MUX: st_next.rdata = st_reg.mux;
        ACR_IDX_DREF: st_next.rdata = st_reg.dref;
        ACR_IDX_IEN: st_next.rdata[ACR_IEN_BIT] = st_reg.ien;
        ACR_IDX_STAT: begin
          st_next.rdata[ACR_STAT_STATE] = st_reg.state;
          st_next.rdata[ACR_STAT_FLAG] = st_reg.flag;
        end
        default: st_next.rresp = ACR_RESP_SLVERR;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // status path: third flop after the pin, so reads see it at three cycles
    if (!frozen) begin
      st_next.state = out_level;
      // a new edge wins over a clear in the same cycle
      st_next.flag = (edge_hit && st_reg.ctrl[ACR_CTRL_EN])
        || (st_reg.flag && !flag_clr);
    end else if (flag_clr) begin
      st_next.flag = 1'b0;
    end

    // comparator halts in standby unless told to keep running
    st_next.active = st_reg.ctrl[ACR_CTRL_EN]
      && (!standby_sleep || st_reg.ctrl[ACR_CTRL_RUNSTBY]);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctrl <= ACR_CTRL_RST;
      st_reg.mux <= ACR_MUX_RST;
      st_reg.dref <= ACR_DREF_RST;
      st_reg.ien <= ACR_IEN_RST[ACR_IEN_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = {{(ACR_DATA_W-8){1'b0}}, st_reg.rdata};
  assign s_axi_rresp = st_reg.rresp;

  assign comp_enable = st_reg.active;
  assign reduced_current_select = st_reg.ctrl[ACR_CTRL_LOWCUR];
  assign hysteresis_level = st_reg.ctrl[ACR_CTRL_HYS_HI:ACR_CTRL_HYS_LO];
  assign positive_input_select = st_reg.mux[ACR_MUX_POS_HI:ACR_MUX_POS_LO];
  assign negative_input_select = st_reg.mux[ACR_MUX_NEG_HI:ACR_MUX_NEG_LO];
  assign divided_reference = st_reg.dref;

  // pin follows the synchronised level; a trade of latency for a glitch-free pad
  assign comp_pin_out = st_reg.state;
  assign comp_pin_oe = st_reg.ctrl[ACR_CTRL_PINEN] && st_reg.active;
  assign comp_event = st_reg.state;

  // level request, drops only when the flag is cleared or enable removed
  assign comparator_irq = st_reg.ien && st_reg.flag;

endmodule

// ### hw/acr_sync.sv
// two-stage level synchroniser for the raw comparator output
`timescale 1ns/1ns
module acr_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic meta;
    logic sync;
  } acr_sync_t;

  acr_sync_t s_reg;
  acr_sync_t s_next;

  // ----------------------------------------
  // the first stage feeds only the second
  // ----------------------------------------
  always_comb begin
    s_next.meta = din;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.sync;

endmodule

// ### tb/acr_analog_model.sv
// behavioural comparator core with its input multiplexers
`timescale 1ns/1ns
module acr_analog_model (
  input wire logic comp_enable,
  input wire logic [1:0] positive_input_select,
  input wire logic [1:0] negative_input_select,
  input wire logic [7:0] divided_reference,
  input wire logic [7:0] pos_lvl [4],
  input wire logic [7:0] neg_lvl [3],
  output logic comp_raw
);
  // levels are in 256ths of the reference; hysteresis and speed not modelled
  logic [7:0] p;
  logic [7:0] n;
  assign p = pos_lvl[positive_input_select];
  assign n = negative_input_select == 2'h3 ? divided_reference
    : neg_lvl[negative_input_select];
  // async level, lands off the clock edge; an idle core reads low
  assign #1 comp_raw = comp_enable && (p > n);
endmodule

// ### tb/acr_regs_properties.sv
// concurrent checks on the comparator register bank ports
`timescale 1ns/1ns
module acr_regs_properties
  import acr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic standby_sleep,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ACR_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_enable,
  input wire logic [7:0] divided_reference,
  input wire logic comp_pin_out,
  input wire logic comp_pin_oe,
  input wire logic comp_event,
  input wire logic comparator_irq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wr_take;
  // any write beat taken may move the enable or the flag
  assign wr_take = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read response late");
  property p_oe; comp_pin_oe |-> comp_enable; endproperty
  a_oe: assert property (p_oe) else $error("pin driven by idle comparator");
  property p_evt; comp_event == comp_pin_out; endproperty
  a_evt: assert property (p_evt) else $error("event and pin level differ");
  property p_irq_hold; comparator_irq && !wr_take |=> comparator_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a clear");
  // a new request needs an output edge, a write or the end of a freeze
  property p_irq_rise;
    $rose(comparator_irq) |-> $changed(comp_event) || $past(wr_take) || $past(standby_sleep);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_rst_val;
    $past(rst) |-> divided_reference == ACR_DREF_RST && !comparator_irq;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad value after reset");
  c_irq: cover property ($rose(comparator_irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == ACR_RESP_SLVERR);
  c_stby: cover property (standby_sleep && comp_enable);
endmodule

// ### tb/comparator_control_regs_tb_top.sv
// self-checking bench for the comparator register bank
`timescale 1ns/1ns
module comparator_control_regs_tb_top;
  import acr_pkg::*;
  logic clock, rst = 1'b1, standby_sleep = 1'b0, comp_raw;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ACR_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [ACR_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, hysteresis_level, positive_input_select;
  logic [1:0] negative_input_select;
  logic comp_enable, reduced_current_select, comp_pin_out, comp_pin_oe, comp_event;
  logic comparator_irq;
  logic [7:0] divided_reference, rd, v, s;
  logic [7:0] pos_lvl [4] = '{8'h00, 8'h00, 8'h00, 8'h10};
  logic [7:0] neg_lvl [3] = '{8'h40, 8'h40, 8'h40};
  logic [1:0] rsp;
  int errors = 0;
  int check_count = 0;
  acr_regs DUT (
    .clock(clock), .rst(rst), .standby_sleep(standby_sleep),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .comp_raw(comp_raw), .comp_enable(comp_enable),
    .reduced_current_select(reduced_current_select), .hysteresis_level(hysteresis_level),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .divided_reference(divided_reference), .comp_pin_out(comp_pin_out),
    .comp_pin_oe(comp_pin_oe), .comp_event(comp_event), .comparator_irq(comparator_irq)
  );
  acr_analog_model u_core (
    .comp_enable(comp_enable), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .divided_reference(divided_reference),
    .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .comp_raw(comp_raw)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic hang();
    errors++;
    end_of_test();
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    int n;
    logic a, w, b;
    @(posedge clock);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (b !== 1'b1) begin
      @(negedge clock);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      n++;
      if (n > 50) hang();
      @(posedge clock);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] ix, input logic [7:0] e);
    int n;
    logic a, r;
    @(posedge clock);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge clock);
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      n++;
      if (n > 50) hang();
      @(posedge clock);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk($sformatf("reg %0h", ix), e, rd);
  endtask
  // new input level, then three cycles through the two-flop synchroniser and the status flop
  task automatic lvl(input logic [7:0] x);
    @(posedge clock);
    pos_lvl[0] <= x;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rchk(ACR_IDX_CTRL, 8'h00);
    rchk(ACR_IDX_MUX, 8'h00);
    rchk(ACR_IDX_DREF, 8'hff);
    rchk(ACR_IDX_IEN, 8'h00);
    rchk(ACR_IDX_STAT, 8'h00);
    rchk(6'h01, 8'h00);
    chk("rresp", 8'(ACR_RESP_SLVERR), 8'(rsp));
    wr(6'h01, 8'hff);
    chk("bresp", 8'(ACR_RESP_SLVERR), 8'(rsp));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, i[0], 2'h0, i[1], i[1:0], 1'b1};
      wr(ACR_IDX_CTRL, v);
      rchk(ACR_IDX_CTRL, v);
      chk("hys", 8'(i), 8'(hysteresis_level));
      chk("lowcur", 8'(i[1]), 8'(reduced_current_select));
      chk("pin_oe", 8'(i[0]), 8'(comp_pin_oe));
      chk("enable", 8'h01, 8'(comp_enable));
      v = {3'h0, i[1:0], 1'b0, 2'(3 - i)};
      wr(ACR_IDX_MUX, v);
      chk("pos", 8'(i), 8'(positive_input_select));
      chk("neg", 8'(3 - i), 8'(negative_input_select));
    end
    wr(ACR_IDX_MUX, 8'hff);
    rchk(ACR_IDX_MUX, ACR_MUX_MASK);
    wr(ACR_IDX_DREF, 8'h5a);
    chk("bresp", 8'(ACR_RESP_OKAY), 8'(rsp));
    rchk(ACR_IDX_DREF, 8'h5a);
    chk("divref", 8'h5a, divided_reference);
    $display("test fields done");
    wr(ACR_IDX_MUX, 8'h03);
    wr(ACR_IDX_IEN, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(ACR_IDX_CTRL, {2'h0, 2'(m), 4'h1});
      wr(ACR_IDX_STAT, 8'h01);
      lvl(8'hff);
      s = {7'h08, 1'(m == 0 || m == 3)};
      rchk(ACR_IDX_STAT, s);
      chk("pin", 8'h01, 8'(comp_pin_out));
      wr(ACR_IDX_STAT, 8'h00);
      rchk(ACR_IDX_STAT, s);
      chk("irq", 8'(s[0]), 8'(comparator_irq));
      wr(ACR_IDX_STAT, 8'h01);
      chk("irq", 8'h00, 8'(comparator_irq));
      lvl(8'h00);
      rchk(ACR_IDX_STAT, 8'(m == 0 || m == 2));
      chk("event", 8'h00, 8'(comp_event));
    end
    $display("test edges done");
    wr(ACR_IDX_STAT, 8'h01);
    wr(ACR_IDX_IEN, 8'h00);
    lvl(8'hff);
    rchk(ACR_IDX_STAT, 8'h11);
    chk("irq", 8'h00, 8'(comparator_irq));
    wr(ACR_IDX_MUX, 8'h83);
    repeat (3) @(posedge clock);
    rchk(ACR_IDX_STAT, 8'h01);
    chk("event", 8'h00, 8'(comp_event));
    chk("pin", 8'h00, 8'(comp_pin_out));
    wr(ACR_IDX_STAT, 8'h01);
    $display("test invert done");
    @(posedge clock);
    standby_sleep <= 1'b1;
    repeat (6) @(posedge clock);
    chk("enable", 8'h00, 8'(comp_enable));
    rchk(ACR_IDX_STAT, 8'h00);
    wr(ACR_IDX_CTRL, 8'hb1);
    // enable lands one edge after the write, look once it has settled
    @(negedge clock);
    chk("enable", 8'h01, 8'(comp_enable));
    @(posedge clock);
    standby_sleep <= 1'b0;
    repeat (3) @(posedge clock);
    lvl(8'h00);
    rchk(ACR_IDX_STAT, 8'h11);
    $display("test standby done");
    end_of_test();
  end
endmodule
bind acr_regs acr_regs_properties u_props (
  .clock(clock), .rst(rst), .standby_sleep(standby_sleep),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .comp_enable(comp_enable), .divided_reference(divided_reference),
  .comp_pin_out(comp_pin_out), .comp_pin_oe(comp_pin_oe), .comp_event(comp_event),
  .comparator_irq(comparator_irq)
);
